//--- acdm_consts.vh
// constants for the current-detection monitor: timing, field widths, gain-1 full-scale range
// included by acdm_core.v and acdm_sampler.v; definitions only
`ifndef ACDM_CONSTS_VH
`define ACDM_CONSTS_VH

// ****************************************
// timing
// ****************************************
`define ACDM_CLK_HZ          10000000
`define ACDM_DET_RATE_SPS    2700
// rounded down so the pacing never runs slower than the detection rate
`define ACDM_DET_DIV         (`ACDM_CLK_HZ / `ACDM_DET_RATE_SPS)

// ****************************************
// widths and reset values
// ****************************************
`define ACDM_SAMPLE_W        24
`define ACDM_COUNT_W         16
`define ACDM_GAIN_W          3
`define ACDM_CH_N            2
`define ACDM_CNT_RST         16'h0000
`define ACDM_FSR_W           24

// ****************************************
// full-scale range in microvolts at gain 1; gain codes 0..7 shift it down for gains 1,2,4..128
// ****************************************
`define ACDM_FSR_G1_UV       24'h124f80

// ****************************************
// modes
// ****************************************
`define ACDM_MODE_CONV       2'h0
`define ACDM_MODE_STBY       2'h1
`define ACDM_MODE_DET        2'h2

`endif

//--- acdm_sampler.v
// sample pacing tick for detection mode, from the internal oscillator
// assumes sys_clk_i is the internal oscillator clock while detecting
`timescale 1ns/100ps
`include "acdm_consts.vh"

module acdm_sampler #(
  parameter DIV = `ACDM_DET_DIV
) (
  input  wire sys_clk_i,
  input  wire sys_rst_i,
  input  wire run_i,
  output reg  tick_o
);

  reg [15:0] cnt_ff;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_ff <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_ff == DIV[15:0] - 16'h0001) begin
      cnt_ff <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule // acdm_sampler

//--- acdm_core.v
// current-detection monitor: standby, detection window and data-ready logic
// assumes the command decoder delivers one-cycle strobes on sys_clk_i,
// and the sync/reset pin arrives asynchronously
//
// How it works
// RQ1: standby command during conversion stops conversion and enters standby.
// RQ2: standby does no conversion and holds data_ready_n high.
// RQ3: sync pulse in standby enters detection only when detect_enable set.
// RQ4: detection samples at 2.7 kSPS from internal oscillator, window configurable.
// RQ5: each sample with magnitude over threshold bumps per-channel exceedance counter.
// RQ6: detection declared only when counter strictly exceeds required count.
// RQ7: all-channels 0 means any channel; 1 means every enabled channel.
// RQ8: after data-ready asserts on detection, return to standby at once.
// RQ9: window ends without detection returns to standby, data-ready untouched.
// RQ10: in detection, data-ready low only for detected current.
// RQ11: in conversion, data-ready pulses low per new sample set.
// RQ12: gain sets full-scale range, 1.2 V halved per gain doubling.
// RQ13: line and neutral channels evaluated together, each against threshold.
// RQ14: each detection entry clears counters and sample count.
`timescale 1ns/100ps
`include "acdm_consts.vh"

module acdm_core #(
  parameter SW  = `ACDM_SAMPLE_W,
  parameter CW  = `ACDM_COUNT_W,
  parameter DIV = `ACDM_DET_DIV
) (
  input  wire                     sys_clk_i,
  input  wire                     sys_rst_i,
  input  wire                     standby_cmd_i,
  input  wire                     wakeup_cmd_i,
  input  wire                     sync_rst_n_i,
  input  wire                     detect_enable_i,
  input  wire                     detect_all_channels_i,
  input  wire [1:0]               chan_enable_i,
  input  wire [SW-1:0]            detect_threshold_i,
  input  wire [CW-1:0]            detect_required_count_i,
  input  wire [CW-1:0]            detect_window_length_i,
  input  wire [`ACDM_GAIN_W-1:0]  input_gain_amp_i,
  input  wire                     conv_valid_i,
  input  wire [SW-1:0]            line_sample_i,
  input  wire [SW-1:0]            neutral_sample_i,
  output reg                      data_ready_n_o,
  output reg  [1:0]               mode_o,
  output reg                      osc_select_o,
  output reg                      det_sample_req_o,
  output reg  [1:0]               detected_ch_o,
  output reg  [`ACDM_FSR_W-1:0]   full_scale_uv_o
);

  // ****************************************
  // helpers
  // ****************************************
  function [SW-1:0] acdm_abs;
    input [SW-1:0] v;
    begin
      acdm_abs = v[SW-1] ? (~v + {{(SW-1){1'b0}}, 1'b1}) : v;
    end
  endfunction

  // mode decode shared by the sampler, the window and the outputs
  function acdm_is_det;
    input [1:0] m;
    begin
      acdm_is_det = (m == `ACDM_MODE_DET);
    end
  endfunction

  // full-scale range halves with each doubling of gain
  function [`ACDM_FSR_W-1:0] acdm_fsr;
    input [`ACDM_GAIN_W-1:0] code;
    begin
      acdm_fsr = `ACDM_FSR_G1_UV >> code;
    end
  endfunction

  // ****************************************
  // pin synchroniser and pulse detect
  // ****************************************
  reg sync_a_ff;
  reg sync_b_ff;
  reg sync_c_ff;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync_a_ff <= 1'b1;
      sync_b_ff <= 1'b1;
      sync_c_ff <= 1'b1;
    end else begin
      sync_a_ff <= sync_rst_n_i;
      sync_b_ff <= sync_a_ff;
      sync_c_ff <= sync_b_ff;
    end
  end

  // a full low pulse counts on its rising edge, so a held-low pin does nothing
  wire sync_pulse = sync_b_ff & ~sync_c_ff;

  // ****************************************
  // state
  // ****************************************
  reg [1:0]    mode_ff;
  reg [1:0]    nxt_mode;
  reg [CW-1:0] exc_ff [0:1];
  reg [CW-1:0] seen_ff;
  reg [1:0]    hit_ff;
  reg          nxt_data_ready_n_n;
  wire         tick;
  wire         in_det    = acdm_is_det(mode_ff);

  acdm_sampler #(
    .DIV (DIV)
  ) u_sampler (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (in_det), // RQ4
    .tick_o    (tick)
  );

  // ****************************************
  // per-channel evaluation
  // ****************************************
  wire [1:0]    over;
  wire [CW-1:0] exc_nxt [0:1];
  wire [1:0]    chan_hit;

  genvar g;
  generate
    for (g = 0; g < `ACDM_CH_N; g = g + 1) begin : g_ch
      wire [SW-1:0] s = (g == 0) ? line_sample_i : neutral_sample_i;
      assign over[g] = chan_enable_i[g] &&
                       (acdm_abs(s) > detect_threshold_i); // RQ5 RQ13
      assign exc_nxt[g] = over[g] ? exc_ff[g] + {{(CW-1){1'b0}}, 1'b1} : exc_ff[g]; // RQ5
      // a channel stays detected for the rest of the window
      assign chan_hit[g] = hit_ff[g] |
                           (over[g] && (exc_nxt[g] > detect_required_count_i)); // RQ6
    end
  endgenerate

  wire [1:0] en_hit    = chan_hit & chan_enable_i;
  wire       any_hit   = |en_hit;
  wire       all_hit   = (en_hit == chan_enable_i) && (|chan_enable_i);
  wire       declare   = detect_all_channels_i ? all_hit : any_hit; // RQ7
  wire [CW-1:0] seen_nxt = seen_ff + {{(CW-1){1'b0}}, 1'b1};
  wire       win_done  = (seen_nxt >= detect_window_length_i);

  // ****************************************
  // mode machine
  // ****************************************
  always @* begin
    nxt_mode   = mode_ff;
    nxt_data_ready_n_n = 1'b1;
    case (mode_ff)
      `ACDM_MODE_CONV: begin
        if (standby_cmd_i) begin
          nxt_mode = `ACDM_MODE_STBY; // RQ1
        end else if (conv_valid_i) begin
          nxt_data_ready_n_n = 1'b0; // RQ11
        end
      end
      `ACDM_MODE_STBY: begin
        nxt_data_ready_n_n = 1'b1; // RQ2
        if (sync_pulse && detect_enable_i) begin
          nxt_mode = `ACDM_MODE_DET; // RQ3
        end else if (wakeup_cmd_i) begin
          nxt_mode = `ACDM_MODE_CONV;
        end
      end
      `ACDM_MODE_DET: begin
        if (standby_cmd_i) begin
          nxt_mode = `ACDM_MODE_STBY;
        end else if (tick) begin
          if (declare) begin
            nxt_data_ready_n_n = 1'b0; // RQ10
            nxt_mode   = `ACDM_MODE_STBY; // RQ8
          end else if (win_done) begin
            nxt_mode = `ACDM_MODE_STBY; // RQ9
          end
        end
      end
      default: begin
        nxt_mode = `ACDM_MODE_STBY;
      end
    endcase
  end

  // ****************************************
  // mode register
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_ff <= `ACDM_MODE_CONV;
    end else begin
      mode_ff <= nxt_mode; // RQ1 RQ3 RQ8 RQ9
    end
  end

  // ****************************************
  // window sample count
  // ****************************************
  // held at zero outside detection, so every entry starts a fresh window
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      seen_ff <= `ACDM_CNT_RST;
    end else if (!in_det) begin
      seen_ff <= `ACDM_CNT_RST; // RQ14
    end else if (tick) begin
      seen_ff <= seen_nxt; // RQ9
    end
  end

  // ****************************************
  // exceedance counters and hit flags
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hit_ff    <= 2'h0;
      exc_ff[0] <= `ACDM_CNT_RST;
      exc_ff[1] <= `ACDM_CNT_RST;
    end else if (!in_det) begin
      hit_ff    <= 2'h0; // RQ14
      exc_ff[0] <= `ACDM_CNT_RST;
      exc_ff[1] <= `ACDM_CNT_RST;
    end else if (tick) begin
      hit_ff    <= chan_hit; // RQ6
      exc_ff[0] <= exc_nxt[0]; // RQ5
      exc_ff[1] <= exc_nxt[1];
    end
  end

  // ****************************************
  // output decode
  // ****************************************
  // mode outputs follow the next-state decode so they line up with mode_o; det_sample_req_o uses in_det instead
  wire nxt_det   = acdm_is_det(nxt_mode);
  wire enter_det = nxt_det & ~in_det;

  // ****************************************
  // data-ready pin
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      data_ready_n_o <= 1'b1;
    end else begin
      data_ready_n_o <= nxt_data_ready_n_n; // RQ2 RQ10 RQ11
    end
  end

  // ****************************************
  // mode report
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mode_o <= `ACDM_MODE_CONV;
    end else begin
      mode_o <= nxt_mode;
    end
  end

  // ****************************************
  // oscillator select
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      osc_select_o <= 1'b0;
    end else begin
      osc_select_o <= nxt_det; // RQ4
    end
  end

  // ****************************************
  // sample request
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      det_sample_req_o <= 1'b0;
    end else begin
      det_sample_req_o <= tick & in_det; // RQ4
    end
  end

  // ****************************************
  // detected channels
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      detected_ch_o <= 2'h0;
    end else if (in_det && tick && declare) begin
      detected_ch_o <= en_hit; // RQ7
    end else if (enter_det) begin
      // kept across standby so the host can read which line tripped
      detected_ch_o <= 2'h0; // RQ14
    end
  end

  // ****************************************
  // full-scale range
  // ****************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      full_scale_uv_o <= `ACDM_FSR_G1_UV;
    end else begin
      full_scale_uv_o <= acdm_fsr(input_gain_amp_i); // RQ12
    end
  end

endmodule // acdm_core

//--- acdm_properties.sv
// port-level checker for acdm_core
// bound to acdm_core; sees only its ports, one clock domain
`timescale 1ns/100ps
module acdm_properties (
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  input wire        standby_cmd_i,
  input wire        conv_valid_i,
  input wire        detect_all_channels_i,
  input wire [1:0]  chan_enable_i,
  input wire [2:0]  input_gain_amp_i,
  input wire        data_ready_n_o,
  input wire [1:0]  mode_o,
  input wire [1:0]  detected_ch_o,
  input wire [23:0] full_scale_uv_o
);
  // ****************************************
  // relations between ports
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_stby_entry: assert property (
    mode_o == 2'h0 && standby_cmd_i |=> mode_o == 2'h1) else $error("no standby");
  chk_stby_quiet: assert property (
    $past(mode_o) == 2'h1 && mode_o == 2'h1 |-> data_ready_n_o) else $error("rdy in standby");
  chk_rdy_pulse: assert property (
    !data_ready_n_o |=> data_ready_n_o) else $error("rdy too long");
  chk_conv_rdy: assert property (
    mode_o == 2'h0 && conv_valid_i && !standby_cmd_i |=> !data_ready_n_o) else $error("no rdy");
  chk_det_source: assert property (
    mode_o == 2'h2 && $past(mode_o) != 2'h2 |-> $past(mode_o) == 2'h1) else $error("bad entry");
  // declaration leaves detection, so while detecting nothing is declared yet
  chk_det_fresh: assert property (
    mode_o == 2'h2 |-> detected_ch_o == 2'h0) else $error("stale hits");
  chk_det_exit: assert property (
    !data_ready_n_o && $past(mode_o) == 2'h2 |-> mode_o == 2'h1 && detected_ch_o != 2'h0)
    else $error("bad exit");
  chk_all_chan: assert property (
    !data_ready_n_o && $past(mode_o) == 2'h2 && detect_all_channels_i
    |-> (detected_ch_o & chan_enable_i) == chan_enable_i) else $error("partial hit");
  chk_fsr_gain: assert property (
    1'b1 |=> full_scale_uv_o == (24'h124f80 >> $past(input_gain_amp_i)))
    else $error("bad range");
endmodule // acdm_properties
bind acdm_core acdm_properties i_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .standby_cmd_i(standby_cmd_i),
  .conv_valid_i(conv_valid_i), .detect_all_channels_i(detect_all_channels_i), .chan_enable_i(chan_enable_i),
  .input_gain_amp_i(input_gain_amp_i), .data_ready_n_o(data_ready_n_o), .mode_o(mode_o),
  .detected_ch_o(detected_ch_o), .full_scale_uv_o(full_scale_uv_o));

//--- acdm_host_model.sv
// host side: standby command strobe and sync/reset pin pulses
// shares the system clock; drives on its falling edge
`timescale 1ns/100ps
module acdm_host_model (
  input  wire sys_clk_i,
  output reg  standby_cmd_o,
  output reg  sync_rst_n_o
);
  initial begin
    standby_cmd_o = 1'b0;
    sync_rst_n_o = 1'b1;
  end
  task send_standby;
    @(negedge sys_clk_i) standby_cmd_o = 1'b1;
    @(negedge sys_clk_i) standby_cmd_o = 1'b0;
  endtask
  // pin held high between pulses, as a host gpio would
  task sync_pulse;
    @(negedge sys_clk_i) sync_rst_n_o = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    sync_rst_n_o = 1'b1;
  endtask
endmodule // acdm_host_model

//--- tb_top.sv
// self-checking bench for acdm_core driven by the host model
// one 10 MHz clock; detection pacing shortened to DIV=4
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  localparam DIV = 4;
  reg         sys_clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg         en = 1'b0, all = 1'b0, cv = 1'b0, wake = 1'b0;
  reg  [1:0]  ch = 2'h1;
  reg  [2:0]  gain = 3'h0;
  reg  [23:0] l = 24'h0, n = 24'h0;
  reg  [15:0] req = 16'h0, len = 16'h1;
  wire        stby, sync_n, data_ready_n, osc, sreq;
  wire [1:0]  mode, hit;
  wire [23:0] fsr;
  integer     fail_count = 0, compares = 0, lows = 0, dcyc = 0, cyc = 0, reqs = 0, k;
  always #50 sys_clk_i = ~sys_clk_i;
  acdm_host_model i_host (.sys_clk_i(sys_clk_i), .standby_cmd_o(stby), .sync_rst_n_o(sync_n));
  acdm_core #(.DIV(DIV)) i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .standby_cmd_i(stby),
    .wakeup_cmd_i(wake), .sync_rst_n_i(sync_n), .detect_enable_i(en), .detect_all_channels_i(all),
    .chan_enable_i(ch), .detect_threshold_i(24'h000100), .detect_required_count_i(req),
    .detect_window_length_i(len), .input_gain_amp_i(gain), .conv_valid_i(cv), .line_sample_i(l),
    .neutral_sample_i(n), .data_ready_n_o(data_ready_n), .mode_o(mode), .osc_select_o(osc),
    .det_sample_req_o(sreq), .detected_ch_o(hit), .full_scale_uv_o(fsr));
  task close_out;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // monitors and hang guard
  // ****************************************
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (data_ready_n === 1'b0) lows = lows + 1;
    if (mode === 2'h2) dcyc = dcyc + 1;
    if (sreq === 1'b1) reqs = reqs + 1;
    if (cyc == 5000) begin
      fail_count++;
      close_out;
    end
  end
  task pulse_cv;
    @(negedge sys_clk_i) cv = 1'b1;
    @(negedge sys_clk_i) cv = 1'b0;
  endtask
  // one detection window from standby; x is the expected hit set, 0 for none
  task run(input e, a, input [1:0] c, input [23:0] lv, nv, input [15:0] r, w, input [1:0] x);
    en = e;
    all = a;
    ch = c;
    l = lv;
    n = nv;
    req = r;
    len = w;
    lows = 0;
    dcyc = 0;
    reqs = 0;
    i_host.sync_pulse;
    k = 0;
    while (e && mode !== 2'h2 && k < 8) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (e) `CHK(osc, 1'b1)
    k = 0;
    while (mode === 2'h2 && k < 100) begin
      @(negedge sys_clk_i);
      k++;
    end
    repeat (3) @(negedge sys_clk_i);
    `CHK(mode, 2'h1)
    `CHK(osc, 1'b0)
    `CHK(reqs, !e ? 0 : (x == 2'h0) ? ((w == 0) ? 1 : w) : r + 1)
    `CHK(lows, (x != 2'h0))
    if (x != 2'h0) `CHK(hit, x)
    if (x != 2'h0) `CHK(dcyc <= (r + 1) * DIV + 3, 1'b1)
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    `CHK(mode, 2'h0)
    `CHK(data_ready_n, 1'b1)
    for (k = 0; k < 8; k++) begin
      @(negedge sys_clk_i) gain = k[2:0];
      @(negedge sys_clk_i);
      `CHK(fsr, 24'h124f80 >> k)
    end
    pulse_cv;
    `CHK(data_ready_n, 1'b0)
    @(negedge sys_clk_i);
    `CHK(data_ready_n, 1'b1)
    i_host.send_standby;
    `CHK(mode, 2'h1)
    lows = 0;
    pulse_cv;
    repeat (2) @(negedge sys_clk_i);
    `CHK(lows, 0)
    run(0, 0, 2'h1, 24'h000200, 24'h0, 0, 4, 2'h0);
    repeat (2) run(1, 0, 2'h1, 24'h000200, 24'h0, 2, 2, 2'h0);
    run(1, 0, 2'h1, 24'h000100, 24'h0, 0, 4, 2'h0);
    run(1, 0, 2'h1, 24'hfffe00, 24'h0, 2, 3, 2'h1);
    run(1, 0, 2'h1, 24'h000080, 24'h0, 0, 4, 2'h0);
    run(1, 0, 2'h1, 24'h000200, 24'h0, 1, 16, 2'h1);
    run(1, 1, 2'h3, 24'h000200, 24'h000080, 0, 3, 2'h0);
    run(1, 0, 2'h3, 24'h000080, 24'h000200, 0, 3, 2'h2);
    run(1, 1, 2'h3, 24'h000200, 24'hfffe00, 0, 3, 2'h3);
    // standby command cuts a window short before its first sample
    i_host.sync_pulse;
    repeat (3) @(negedge sys_clk_i);
    `CHK(mode, 2'h2)
    i_host.send_standby;
    `CHK(mode, 2'h1)
    `CHK(data_ready_n, 1'b1)
    // wake-up strobe returns to conversion, where data-ready pulses again
    @(negedge sys_clk_i) wake = 1'b1;
    @(negedge sys_clk_i) wake = 1'b0;
    `CHK(mode, 2'h0)
    pulse_cv;
    `CHK(data_ready_n, 1'b0)
    close_out;
  end
endmodule // tb_top
